// *** core/dims_pkg.sv ***
// Package: constants and types for the drive input mode select block
`default_nettype none
package dims_pkg;
  localparam int          NUM_INPUTS       = 9;
  localparam int          MODE_W           = 5;
  localparam logic [4:0]  MODE_RST         = 5'h01;
  localparam logic [4:0]  MODE_MIN         = 5'h01;
  localparam logic [4:0]  MODE_MAX         = 5'h10;
  localparam logic [4:0]  MODE_3W_LO       = 5'h02;
  localparam logic [4:0]  MODE_3W_HI       = 5'h06;
  localparam logic [4:0]  MODE_MOM_LO      = 5'h07;
  localparam logic [4:0]  MODE_MOM_HI      = 5'h0B;
  localparam logic [4:0]  MODE_2W_LO       = 5'h0C;
  localparam logic [4:0]  MODE_2W_HI       = 5'h10;
  localparam logic [3:0]  MODE_OFS_MAX     = 4'h4;
  // Terminal positions (bit index into the contact input vector)
  localparam int          IN_STOP          = 0;
  localparam int          IN_START         = 1;
  localparam int          IN_DIR           = 2;
  localparam int          IN_ENABLE        = 3;
  localparam int          IN_AUX           = 4;
  localparam int          IN_SPD1          = 5;
  localparam int          IN_SPD2          = 6;
  localparam int          IN_SPD3          = 7;
  localparam int          IN_LOCAL         = 8;
  localparam int          IN_FWD           = 1;
  localparam int          IN_REV           = 2;
  localparam int          IN_RUN_FWD       = 1;
  localparam int          IN_RUN_REV       = 2;
  // Speed select word positions
  localparam int          SPD_BIT3         = 14;
  localparam int          SPD_BIT2         = 13;
  localparam int          SPD_BIT1         = 12;
  localparam logic [2:0]  SPD_LAST         = 3'h0;
  localparam logic [2:0]  SPD_EXT1         = 3'h1;
  localparam logic [2:0]  SPD_EXT2         = 3'h7;
  localparam logic [2:0]  REF_RST          = 3'h1;
  localparam int          PANEL_PORT       = 1;
  localparam int          PORTS            = 6;

  typedef enum logic [1:0] {
    DIMS_CTL_STOPPED = 2'b00,
    DIMS_CTL_RUNNING = 2'b01
  } dims_ctl_type;

  typedef enum logic [2:0] {
    DIMS_FAM_STOP_EN  = 3'h0,
    DIMS_FAM_THREE_W  = 3'h1,
    DIMS_FAM_MOMENT   = 3'h3,
    DIMS_FAM_TWO_W    = 3'h2,
    DIMS_FAM_INVALID  = 3'h6
  } dims_fam_type;
endpackage
`default_nettype wire

// *** core/dims_sync.sv ***
// Two-stage synchroniser, one per contact input
`default_nettype none
module dims_sync #(
  parameter int WIDTH = 9
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  if (WIDTH < 1) begin : g_bad_width
    $error("dims_sync: WIDTH must be at least 1");
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_ff[g]  <= 1'b0;
          sync_out[g] <= 1'b0;
        end else begin
          meta_ff[g]  <= async_in[g];
          sync_out[g] <= meta_ff[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** core/dims_top.sv ***
// Maps nine contact inputs to drive commands according to the latched input mode
// Notes on behaviour
// RULE1: Mode value selects fixed input function set
// RULE2: New mode applies only after power cycle
// RULE3: Terminal meanings follow the latched mode
// RULE4: Mode 1: only stop and enable used
// RULE5: Modes 2-6: three-wire start, maintained direction
// RULE6: Modes 2-6: direction from one chosen source
// RULE7: Modes 7-11: momentary start and direction, parallel
// RULE8: Modes 12-16: two-wire run, others ignored
// RULE9: Local control granted only while stopped
// RULE10: Local control blocks others except stop
// RULE11: No start without permissives including enable
// RULE12: Speed selects decode to reference source
// RULE13: Default settings allow full panel functions
// RULE14: Drive-mounted panel is communication port one
// RULE15: Output runs only while enable true
// RULE16: Auxiliary fault whenever interlock open
// RULE17: Absent board needs mode programmed to one
// RULE18: Inputs synchronised before any decoding
`default_nettype none
module dims_top
  import dims_pkg::*;
#(
  parameter int                NUM_IN  = dims_pkg::NUM_INPUTS,
  parameter logic [5:0]        PNL_MSK = 6'h3F
) (
  input  wire logic                      ref_clk,
  input  wire logic                      arst_n,
  input  wire logic [dims_pkg::NUM_INPUTS-1:0] contact_in,
  input  wire logic [dims_pkg::MODE_W-1:0]     mode_prog,
  input  wire logic                      power_up_load,
  input  wire logic                      dir_from_terminal,
  input  wire logic [dims_pkg::PORTS-1:0] logic_mask,
  input  wire logic [dims_pkg::PORTS-1:0] port_start,
  input  wire logic [dims_pkg::PORTS-1:0] port_stop,
  input  wire logic [dims_pkg::PORTS-1:0] port_fwd,
  input  wire logic [dims_pkg::PORTS-1:0] port_rev,
  input  wire logic                      motor_stopped,
  output logic                           run_cmd_ff,
  output logic                           dir_rev_ff,
  output logic                           output_enable_ff,
  output logic                           aux_fault_ff,
  output logic                           local_ctl_ff,
  output logic [dims_pkg::MODE_W-1:0]    mode_active_ff,
  output logic [2:0]                     ref_src_ff,
  output logic                           ref_hold_ff,
  output logic [15:0]                    speed_word_ff,
  output logic                           mode_invalid_ff
);
  import dims_pkg::*;

  if (NUM_IN != NUM_INPUTS) begin : g_bad_num_in
    $error("dims_top: terminal map is fixed at nine inputs");
  end

  logic [NUM_INPUTS-1:0] in_s;
  logic [NUM_INPUTS-1:0] in_d_ff;
  dims_fam_type          fam;
  dims_ctl_type          ctl_ff;
  logic [PORTS-1:0]      port_ok;
  logic                  any_stop;
  logic                  permit;
  logic                  nxt_run;
  logic                  nxt_dir;
  logic                  nxt_local;
  logic                  start_edge;
  logic                  panel_start;
  logic                  panel_fwd;
  logic                  panel_rev;
  logic [2:0]            spd;

  dims_sync #(
    .WIDTH (NUM_INPUTS)
  ) u_sync (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .async_in (contact_in),
    .sync_out (in_s)
  ); // RULE18

  // Mode is caught only on the power-up load strobe, never live
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_active_ff  <= MODE_RST;
      mode_invalid_ff <= 1'b0;
    end else if (power_up_load) begin // RULE2
      if (mode_prog >= MODE_MIN && mode_prog <= MODE_MAX) begin
        mode_active_ff  <= mode_prog;
        mode_invalid_ff <= 1'b0;
      end else begin
        mode_active_ff  <= MODE_RST;
        mode_invalid_ff <= 1'b1;
      end
    end
  end

  always_comb begin
    if (mode_active_ff >= MODE_2W_LO && mode_active_ff <= MODE_2W_HI) begin
      fam = DIMS_FAM_TWO_W;
    end else if (mode_active_ff >= MODE_MOM_LO) begin
      fam = DIMS_FAM_MOMENT;
    end else if (mode_active_ff >= MODE_3W_LO) begin
      fam = DIMS_FAM_THREE_W;
    end else begin
      fam = DIMS_FAM_STOP_EN;
    end
  end // RULE1 RULE3

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_d_ff <= '0;
    end else begin
      in_d_ff <= in_s;
    end
  end

  // Panel is port 1; its mask bit defaults set so the panel has full control
  always_comb begin
    port_ok = logic_mask & PNL_MSK; // RULE13 RULE14
    if (local_ctl_ff) begin
      port_ok = '0; // RULE10
    end
    panel_start = |(port_start & port_ok);
    panel_fwd   = |(port_fwd & port_ok);
    panel_rev   = |(port_rev & port_ok);
  end

  // Stop is honoured from every port whatever the mask, and in modes 12-16 port stop counts only under local control
  assign any_stop = (|port_stop) | ~in_s[IN_STOP]; // RULE10
  assign permit   = in_s[IN_ENABLE] & in_s[IN_AUX]; // RULE11
  assign start_edge = in_s[IN_START] & ~in_d_ff[IN_START];

  always_comb begin
    nxt_run = run_cmd_ff;
    nxt_dir = dir_rev_ff;
    case (fam)
      DIMS_FAM_STOP_EN: begin
        if (panel_start) nxt_run = 1'b1; // RULE4
        if (panel_fwd) nxt_dir = 1'b0;
        if (panel_rev) nxt_dir = 1'b1;
        if (any_stop) nxt_run = 1'b0;
      end
      DIMS_FAM_THREE_W: begin
        if (start_edge || panel_start) nxt_run = 1'b1; // RULE5
        if (dir_from_terminal) begin
          nxt_dir = in_s[IN_DIR]; // RULE6
        end else begin
          if (panel_fwd) nxt_dir = 1'b0;
          if (panel_rev) nxt_dir = 1'b1;
        end
        if (any_stop) nxt_run = 1'b0;
      end
      DIMS_FAM_MOMENT: begin
        if (start_edge || panel_start) nxt_run = 1'b1; // RULE7
        if ((in_s[IN_FWD] & ~in_d_ff[IN_FWD]) || panel_fwd) nxt_dir = 1'b0;
        if ((in_s[IN_REV] & ~in_d_ff[IN_REV]) || panel_rev) nxt_dir = 1'b1;
        if (any_stop) nxt_run = 1'b0;
      end
      DIMS_FAM_TWO_W: begin
        // Panel start and direction ignored; only terminals run the motor
        nxt_run = in_s[IN_RUN_FWD] ^ in_s[IN_RUN_REV]; // RULE8
        if (nxt_run) nxt_dir = in_s[IN_RUN_REV];
        // Port stop only counts under local control, where every stop is honoured
        if (!in_s[IN_STOP] || (local_ctl_ff && (|port_stop))) nxt_run = 1'b0; // RULE8 RULE10
      end
      default: begin
        nxt_run = 1'b0;
      end
    endcase
    if (!permit) nxt_run = 1'b0; // RULE11 RULE15
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_cmd_ff <= 1'b0;
      dir_rev_ff <= 1'b0;
      ctl_ff     <= DIMS_CTL_STOPPED;
    end else begin
      run_cmd_ff <= nxt_run;
      dir_rev_ff <= nxt_dir;
      ctl_ff     <= motor_stopped ? DIMS_CTL_STOPPED : DIMS_CTL_RUNNING;
    end
  end

  // Request while running is dropped, not queued; a held input retakes it later
  always_comb begin
    nxt_local = local_ctl_ff;
    if (!in_s[IN_LOCAL] || fam == DIMS_FAM_STOP_EN) begin
      nxt_local = 1'b0;
    end else if (ctl_ff == DIMS_CTL_STOPPED && motor_stopped) begin
      nxt_local = 1'b1; // RULE9
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      local_ctl_ff <= 1'b0;
    end else begin
      local_ctl_ff <= nxt_local;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      output_enable_ff <= 1'b0;
      aux_fault_ff     <= 1'b0;
    end else begin
      output_enable_ff <= in_s[IN_ENABLE]; // RULE15
      aux_fault_ff     <= ~in_s[IN_AUX]; // RULE16
    end
  end

  assign spd = {in_s[IN_SPD3], in_s[IN_SPD2], in_s[IN_SPD1]};

  // Code 000 holds the previous source so the reference does not jump
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_src_ff    <= REF_RST;
      ref_hold_ff   <= 1'b0;
      speed_word_ff <= 16'h0000;
    end else begin
      speed_word_ff <= '0;
      speed_word_ff[SPD_BIT3] <= spd[2]; // RULE12
      speed_word_ff[SPD_BIT2] <= spd[1];
      speed_word_ff[SPD_BIT1] <= spd[0];
      ref_hold_ff <= (spd == SPD_LAST);
      if (spd != SPD_LAST) begin
        ref_src_ff <= spd; // RULE12
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/dims_field_model.sv ***
// Field contact model driving the nine terminal inputs
`default_nettype none
module dims_field_model (
  input  wire logic       ref_clk,
  input  wire logic [8:0] want,
  output var  logic [8:0] contact_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial contact_in = 9'h000;
  // Closures land only after an edge, never in the sampling step
  always @(posedge ref_clk) contact_in <= want;
endmodule
`default_nettype wire

// *** dv/dims_monitor.sv ***
// Concurrent checks on the ports of the input mode select top
`default_nettype none
module dims_monitor (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic [8:0]  contact_in,
  input wire logic [4:0]  mode_prog,
  input wire logic        power_up_load,
  input wire logic        motor_stopped,
  input wire logic        run_cmd_ff,
  input wire logic        output_enable_ff,
  input wire logic        aux_fault_ff,
  input wire logic        local_ctl_ff,
  input wire logic [4:0]  mode_active_ff,
  input wire logic        ref_hold_ff,
  input wire logic [15:0] speed_word_ff,
  input wire logic        mode_invalid_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Two sync flops plus the output flop: contacts show three edges on
  sequence s_settled; $past(arst_n, 4); endsequence
  sequence s_permit; output_enable_ff && !aux_fault_ff; endsequence
  sequence s_aux_ok; aux_fault_ff == !$past(contact_in[4], 3); endsequence
  sequence s_enable_ok; output_enable_ff == $past(contact_in[3], 3); endsequence
  sequence s_word_ok; speed_word_ff == {1'b0, $past(contact_in[7:5], 3), 12'h000}; endsequence
  sequence s_hold_ok; ref_hold_ff == ($past(contact_in[7:5], 3) == 3'h0); endsequence
  sequence s_mode_ok;
    mode_active_ff == (($past(mode_prog) >= 5'h01 && $past(mode_prog) <= 5'h10) ?
                       $past(mode_prog) : 5'h01);
  endsequence
  sequence s_mode_same; $stable({mode_active_ff, mode_invalid_ff}); endsequence
  sequence s_stopped_two; $past(motor_stopped) && $past(motor_stopped, 2); endsequence
  a_aux_fault_open: assert property (s_settled |-> s_aux_ok)
    else $error("aux fault does not follow interlock");
  a_enable_follow: assert property (s_settled |-> s_enable_ok)
    else $error("output enable does not follow enable input");
  a_speed_word_map: assert property (s_settled |-> s_word_ok)
    else $error("speed word bits wrong");
  a_speed_hold_code: assert property (s_settled |-> s_hold_ok)
    else $error("hold flag wrong");
  a_mode_load_value: assert property (power_up_load |=> s_mode_ok)
    else $error("latched mode wrong");
  a_mode_keep_value: assert property (!power_up_load |=> s_mode_same)
    else $error("mode changed without load");
  a_run_needs_permit: assert property ($rose(run_cmd_ff) |-> s_permit)
    else $error("run without permissives");
  a_local_when_stopped: assert property ($rose(local_ctl_ff) |-> s_stopped_two)
    else $error("local granted while running");
  a_local_not_mode1: assert property ($rose(local_ctl_ff) |-> mode_active_ff != 5'h01)
    else $error("local granted in mode one");
endmodule
bind dims_top dims_monitor i_dims_monitor (.ref_clk(ref_clk), .arst_n(arst_n),
  .contact_in(contact_in), .mode_prog(mode_prog), .power_up_load(power_up_load),
  .motor_stopped(motor_stopped), .run_cmd_ff(run_cmd_ff), .output_enable_ff(output_enable_ff),
  .aux_fault_ff(aux_fault_ff), .local_ctl_ff(local_ctl_ff), .mode_active_ff(mode_active_ff),
  .ref_hold_ff(ref_hold_ff), .speed_word_ff(speed_word_ff), .mode_invalid_ff(mode_invalid_ff));
`default_nettype wire

// *** dv/dims_top_tb_top.sv ***
// Self-checking bench for the drive input mode select block
`default_nettype none
module dims_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dims_pkg::*;
  logic        ref_clk = 1'b0, arst_n = 1'b0, power_up_load = 1'b0;
  logic        dir_from_terminal = 1'b1, motor_stopped = 1'b1;
  logic [8:0]  want = 9'h019, contact_in;
  logic [4:0]  mode_prog = 5'h01, mode;
  logic [5:0]  logic_mask = 6'h3F, port_start = 6'h00, port_stop = 6'h00;
  logic [5:0]  port_fwd = 6'h00, port_rev = 6'h00;
  logic        run, rev, oen, aux, loc, hold, inval;
  logic [2:0]  src, code, last;
  logic [15:0] word;
  int          num_errors = 0, compares = 0;
  dims_field_model i_dims_field_model (.ref_clk(ref_clk), .want(want), .contact_in(contact_in));
  dims_top i_dims_top (.ref_clk(ref_clk), .arst_n(arst_n), .contact_in(contact_in),
    .mode_prog(mode_prog), .power_up_load(power_up_load), .dir_from_terminal(dir_from_terminal),
    .logic_mask(logic_mask), .port_start(port_start), .port_stop(port_stop),
    .port_fwd(port_fwd), .port_rev(port_rev), .motor_stopped(motor_stopped),
    .run_cmd_ff(run), .dir_rev_ff(rev), .output_enable_ff(oen), .aux_fault_ff(aux),
    .local_ctl_ff(loc), .mode_active_ff(mode), .ref_src_ff(src), .ref_hold_ff(hold),
    .speed_word_ff(word), .mode_invalid_ff(inval));
  always #25 ref_clk = ~ref_clk;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic set(input logic [8:0] c);
    @(posedge ref_clk);
    want <= c;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  task automatic ports(input logic [5:0] s, input logic [5:0] p, input logic [5:0] r);
    @(posedge ref_clk);
    port_start <= s;
    port_stop <= p;
    port_rev <= r;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic load(input logic [4:0] m);
    @(posedge ref_clk);
    mode_prog <= m;
    power_up_load <= 1'b1;
    @(posedge ref_clk);
    power_up_load <= 1'b0;
    // Reprogramming after the latch must stay invisible
    mode_prog <= ~m;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("mode", (m >= 5'h01 && m <= 5'h10) ? m : 5'h01, mode);
    chk("invalid", !(m >= 5'h01 && m <= 5'h10), inval);
  endtask
  initial begin
    repeat (4000) @(posedge ref_clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hA028F2B7));
    repeat (12) @(posedge ref_clk);
    chk("mode_rst", 16'h0001, mode);
    chk("src_rst", 16'h0001, src);
    arst_n <= 1'b1;
    load(5'h00);
    load(5'h1F);
    load(5'h01);
    ports(6'h02, 6'h00, 6'h00);
    chk("run", 1'b1, run);
    ports(6'h00, 6'h02, 6'h00);
    chk("run", 1'b0, run);
    logic_mask <= 6'h3D;
    ports(6'h02, 6'h00, 6'h00);
    chk("run", 1'b0, run);
    ports(6'h04, 6'h00, 6'h00);
    chk("run", 1'b1, run);
    ports(6'h00, 6'h02, 6'h00);
    chk("run", 1'b0, run);
    logic_mask <= 6'h3F;
    ports(6'h00, 6'h00, 6'h00);
    set(9'h01B);
    chk("run", 1'b0, run);
    set(9'h019);
    load(5'h02);
    set(9'h01B);
    chk("run", 1'b1, run);
    set(9'h01F);
    chk("dir", 1'b1, rev);
    ports(6'h00, 6'h00, 6'h02);
    set(9'h01B);
    chk("dir", 1'b0, rev);
    dir_from_terminal <= 1'b0;
    set(9'h01F);
    chk("dir", 1'b1, rev);
    // Terminal still says reverse; only the port forward may turn it
    port_fwd <= 6'h02;
    ports(6'h00, 6'h00, 6'h00);
    chk("dir", 1'b0, rev);
    port_fwd <= 6'h00;
    dir_from_terminal <= 1'b1;
    set(9'h018);
    chk("run", 1'b0, run);
    set(9'h011);
    set(9'h013);
    chk("run", 1'b0, run);
    chk("enable", 1'b0, oen);
    set(9'h009);
    set(9'h00B);
    chk("run", 1'b0, run);
    chk("aux", 1'b1, aux);
    set(9'h019);
    chk("aux", 1'b0, aux);
    motor_stopped <= 1'b0;
    set(9'h119);
    chk("local", 1'b0, loc);
    motor_stopped <= 1'b1;
    set(9'h119);
    chk("local", 1'b1, loc);
    ports(6'h02, 6'h00, 6'h00);
    chk("run", 1'b0, run);
    ports(6'h00, 6'h00, 6'h00);
    set(9'h019);
    load(5'h07);
    set(9'h01B);
    set(9'h019);
    chk("run", 1'b1, run);
    ports(6'h00, 6'h00, 6'h02);
    chk("dir", 1'b1, rev);
    ports(6'h00, 6'h00, 6'h00);
    set(9'h018);
    load(5'h0C);
    set(9'h019);
    ports(6'h02, 6'h00, 6'h00);
    chk("run", 1'b0, run);
    ports(6'h00, 6'h00, 6'h00);
    set(9'h01D);
    chk("dir", 1'b1, rev);
    set(9'h01F);
    chk("run", 1'b0, run);
    set(9'h01B);
    chk("run", 1'b1, run);
    ports(6'h00, 6'h02, 6'h00);
    chk("run", 1'b1, run);
    ports(6'h00, 6'h00, 6'h00);
    last = 3'h1;
    for (int i = 0; i < 14; i++) begin
      code = (i < 8) ? i[2:0] : 3'($urandom_range(7));
      set({1'b0, code, 5'h19});
      if (code != 3'h0) last = code;
      chk("word", {1'b0, code, 12'h000}, word);
      chk("hold", code == 3'h0, hold);
      chk("src", last, src);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
